/* File: pcg_top.sv */
// Peripheral clock gating control with its APB register slave
// Function
// - Bit one runs peripheral clock, zero stops
// - Watchdog, GPIO, pins, system control always clocked
// - Bit 19 gates second two-wire interface
// - Peripheral access valid only while enabled
// - Bits 1, 2 gate timers 0, 1
// - Bits 3, 4 gate serial ports 0, 1
// - Bit 5 gates pulse-width modulator
// - Bits 7, 8 gate two-wire0, sync serial0
// - Bits 9, 10 gate calendar, sync serial1
// - Bit 12 gates first converter
// - Reserved bits written zero, read undefined
`timescale 1ns/10ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] periph_sel,
  input wire logic periph_enable,
  output logic [31:0] periph_sel_gated,
  output logic periph_blocked_ready,
  output logic periph_blocked_err,
  input wire logic converter_power_down,
  output logic [31:0] clock_enable_vec,
  output pcg_enables_t clock_enables
);

  // ------------------------------------------------------------
  // Bus request
  // ------------------------------------------------------------
  pcg_apb_req_t req;

  assign req.setup = psel && !penable;
  assign req.access = psel && penable;
  assign req.write = pwrite;
  assign req.addr = paddr;
  assign req.wdata = pwdata;
  assign req.strb = pstrb;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic hit_ctrl;
  logic hit_status;
  logic hit_state;
  logic hit_any;

  assign hit_ctrl = (req.addr == PCG_POWER_CTRL_ADDR);
  assign hit_status = (req.addr == PCG_STATUS_ADDR);
  assign hit_state = (req.addr == PCG_CLK_STATE_ADDR);
  assign hit_any = hit_ctrl || hit_status || hit_state;

  logic wr_ctrl;
  logic wr_status;

  assign wr_ctrl = req.access && req.write && hit_ctrl;
  assign wr_status = req.access && req.write && hit_status;

  // ------------------------------------------------------------
  // Byte lane merge
  // ------------------------------------------------------------
  function automatic logic [31:0] pcg_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < PCG_LANES; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // Gating register
  // ------------------------------------------------------------
  logic [31:0] power_ctrl_reg;
  logic [31:0] power_ctrl_next;

  // Reserved bits never store, so stray ones do no harm
  always_comb begin
    power_ctrl_next = power_ctrl_reg;
    if (wr_ctrl) begin
      power_ctrl_next = pcg_merge(power_ctrl_reg, req.wdata,
                                  req.strb) & PCG_IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_ctrl_reg <= PCG_POWER_CTRL_RESET;
    end else begin
      power_ctrl_reg <= power_ctrl_next;
    end
  end

  // ------------------------------------------------------------
  // Per channel enables
  // ------------------------------------------------------------
  logic [31:0] enable_vec;

  // A disable waits for a transfer in flight to that peripheral
  for (genvar i = 0; i < 32; i++) begin : g_chan
    if (PCG_IMPL_MASK[i]) begin : g_impl
      pcg_enable_hold u_hold (
        .clk(clk),
        .rst_n(rst_n),
        .enable_request(power_ctrl_reg[i]),
        .channel_busy(periph_sel[i]),
        .enable_reg(enable_vec[i])
      );
    end else begin : g_none
      assign enable_vec[i] = 1'b0;
    end
  end

  assign clock_enable_vec = enable_vec;

  // ------------------------------------------------------------
  // Named clock enables
  // ------------------------------------------------------------
  // No gating bit exists for these, so they are tied on
  assign clock_enables.watchdog = 1'b1;
  assign clock_enables.gpio = 1'b1;
  assign clock_enables.pin_connect = 1'b1;
  assign clock_enables.system_control = 1'b1;

  assign clock_enables.timer0 = enable_vec[PCG_BIT_TIMER0];
  assign clock_enables.timer1 = enable_vec[PCG_BIT_TIMER1];

  assign clock_enables.serial_port0 = enable_vec[PCG_BIT_SERIAL0];
  assign clock_enables.serial_port1 = enable_vec[PCG_BIT_SERIAL1];

  assign clock_enables.pulse_modulator = enable_vec[PCG_BIT_PULSE];

  assign clock_enables.two_wire0 = enable_vec[PCG_BIT_TWO_WIRE0];
  assign clock_enables.sync_serial0 = enable_vec[PCG_BIT_SYNC0];

  assign clock_enables.calendar = enable_vec[PCG_BIT_CALENDAR];
  assign clock_enables.sync_serial1 = enable_vec[PCG_BIT_SYNC1];

  assign clock_enables.converter0 = enable_vec[PCG_BIT_CONV0];

  assign clock_enables.two_wire1 = enable_vec[PCG_BIT_TWO_WIRE1];

  // ------------------------------------------------------------
  // Peripheral access gate
  // ------------------------------------------------------------
  logic blocked_event;

  pcg_access_gate u_gate (
    .periph_sel(periph_sel),
    .periph_enable(periph_enable),
    .enable_vec(enable_vec),
    .periph_sel_gated(periph_sel_gated),
    .blocked_ready(periph_blocked_ready),
    .blocked_err(periph_blocked_err),
    .blocked_event(blocked_event)
  );

  // ------------------------------------------------------------
  // Converter sequencing monitor
  // ------------------------------------------------------------
  logic conv_seq_event;

  // Power-down on with clock off means a wrong order was used
  assign conv_seq_event = converter_power_down &&
                          !enable_vec[PCG_BIT_CONV0];

  // ------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------
  logic [1:0] status_reg;
  logic [1:0] status_set;
  logic [1:0] status_clr;

  assign status_set = {blocked_event, conv_seq_event};
  assign status_clr = wr_status && req.strb[0] ?
                      req.wdata[1:0] : 2'h0;

  // Set wins over clear, so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= PCG_STATUS_RESET;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [31:0] rdata_mux;
  logic [31:0] prdata_reg;

  always_comb begin
    rdata_mux = 32'h00000000;
    if (hit_ctrl) begin
      rdata_mux = power_ctrl_reg & PCG_IMPL_MASK;
    end else if (hit_status) begin
      rdata_mux = {30'h00000000, status_reg};
    end else if (hit_state) begin
      rdata_mux = enable_vec;
    end
  end

  // Captured in setup so the access phase sees a stable word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
    end else if (req.setup && !req.write) begin
      prdata_reg <= rdata_mux;
    end
  end

  assign prdata = prdata_reg;

  // ------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------
  // No wait states: every access completes in its first cycle
  assign pready = 1'b1;
  assign pslverr = req.access && !hit_any;

endmodule
`default_nettype wire

/* File: pcg_pkg.sv */
// Constants and types of the peripheral clock gating block
package pcg_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int PCG_DW = 32;
  localparam int PCG_LANES = 4;
  localparam logic [31:0] PCG_POWER_CTRL_ADDR = 32'hE01FC0C4;
  localparam logic [31:0] PCG_STATUS_ADDR = 32'hE01FC1F0;
  localparam logic [31:0] PCG_CLK_STATE_ADDR = 32'hE01FC1F4;

  // ------------------------------------------------------------
  // Field positions of the gating register
  // ------------------------------------------------------------
  localparam int PCG_BIT_TIMER0 = 1;
  localparam int PCG_BIT_TIMER1 = 2;
  localparam int PCG_BIT_SERIAL0 = 3;
  localparam int PCG_BIT_SERIAL1 = 4;
  localparam int PCG_BIT_PULSE = 5;
  localparam int PCG_BIT_TWO_WIRE0 = 7;
  localparam int PCG_BIT_SYNC0 = 8;
  localparam int PCG_BIT_CALENDAR = 9;
  localparam int PCG_BIT_SYNC1 = 10;
  localparam int PCG_BIT_CONV0 = 12;
  localparam int PCG_BIT_TWO_WIRE1 = 19;

  // Implemented gating bits, all set at reset
  localparam logic [31:0] PCG_IMPL_MASK = 32'h000817BE;
  localparam logic [31:0] PCG_POWER_CTRL_RESET = PCG_IMPL_MASK;

  // ------------------------------------------------------------
  // Status register fields, write one to clear
  // ------------------------------------------------------------
  localparam int PCG_ST_CONV_SEQ = 0;
  localparam int PCG_ST_BLOCKED = 1;
  localparam logic [1:0] PCG_STATUS_RESET = 2'h0;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic watchdog;
    logic gpio;
    logic pin_connect;
    logic system_control;
    logic timer0;
    logic timer1;
    logic serial_port0;
    logic serial_port1;
    logic pulse_modulator;
    logic two_wire0;
    logic sync_serial0;
    logic calendar;
    logic sync_serial1;
    logic converter0;
    logic two_wire1;
  } pcg_enables_t;

  typedef struct packed {
    logic setup;
    logic access;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } pcg_apb_req_t;

endpackage

/* File: pcg_enable_hold.sv */
// One channel of clock enable, holding off a disable during a transfer
`timescale 1ns/10ps
`default_nettype none
module pcg_enable_hold
  import pcg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable_request,
  input wire logic channel_busy,
  output logic enable_reg
);

  // ------------------------------------------------------------
  // Enable state
  // ------------------------------------------------------------
  logic enable_next;

  // Rising enable acts at once; falling waits for the bus to idle
  always_comb begin
    enable_next = enable_reg;
    if (enable_request) begin
      enable_next = 1'b1;
    end else if (!channel_busy) begin
      enable_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= 1'b1;
    end else begin
      enable_reg <= enable_next;
    end
  end

endmodule
`default_nettype wire

/* File: pcg_access_gate.sv */
// Gate of peripheral selects by the effective clock enables
`timescale 1ns/10ps
`default_nettype none
module pcg_access_gate
  import pcg_pkg::*;
(
  input wire logic [31:0] periph_sel,
  input wire logic periph_enable,
  input wire logic [31:0] enable_vec,
  output logic [31:0] periph_sel_gated,
  output logic blocked_ready,
  output logic blocked_err,
  output logic blocked_event
);

  // ------------------------------------------------------------
  // Select gating
  // ------------------------------------------------------------
  logic [31:0] allow_vec;
  logic [31:0] blocked_vec;

  // Ungated numbers pass: those peripherals never stop
  assign allow_vec = enable_vec | ~PCG_IMPL_MASK;
  assign periph_sel_gated = periph_sel & allow_vec;
  assign blocked_vec = periph_sel & ~allow_vec;

  // A stopped peripheral cannot answer, so the gate does it
  assign blocked_ready = periph_enable && (|blocked_vec);
  assign blocked_err = blocked_ready;
  assign blocked_event = blocked_ready;

endmodule
`default_nettype wire

/* File: pcg_properties.sv */
// Assertion checker of the peripheral clock gating block
`timescale 1ns/10ps
`default_nettype none
module pcg_properties
  import pcg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] periph_sel,
  input wire logic periph_enable,
  input wire logic [31:0] periph_sel_gated,
  input wire logic periph_blocked_ready,
  input wire logic periph_blocked_err,
  input wire logic [31:0] clock_enable_vec,
  input wire pcg_enables_t clock_enables
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  localparam logic [31:0] M = PCG_IMPL_MASK;
  logic acc;
  logic mapped;
  logic wctl;
  logic [31:0] v;
  assign v = clock_enable_vec;
  assign acc = psel && penable;
  assign mapped = paddr == PCG_POWER_CTRL_ADDR ||
    paddr == PCG_STATUS_ADDR || paddr == PCG_CLK_STATE_ADDR;
  assign wctl = acc && pwrite && paddr == PCG_POWER_CTRL_ADDR &&
    pstrb == 4'hF;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ready_const: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_fixed_on: assert property (clock_enables[14:11] == 4'hF)
    else $error("ungated clock stopped");
  a_timer_map: assert property (clock_enables[10:6] ==
    {v[1], v[2], v[3], v[4], v[5]}) else $error("enable map wrong");
  a_other_map: assert property (clock_enables[5:0] ==
    {v[7], v[8], v[9], v[10], v[12], v[19]})
    else $error("enable map wrong");
  a_reserved_zero: assert property ((v & ~M) == 32'h0)
    else $error("reserved enable set");
  a_gate_select: assert property
    (((periph_sel_gated ^ (periph_sel & v)) & M) == 32'h0)
    else $error("select not gated");
  a_block_err: assert property (periph_enable &&
    |(periph_sel & M & ~v) |-> periph_blocked_ready && periph_blocked_err)
    else $error("blocked access not refused");
  a_enable_follow: assert property (wctl |-> ##2
    ((v & $past(pwdata, 2) & M) == ($past(pwdata, 2) & M)))
    else $error("clock enable did not follow write");
  a_reset_set: assert property ($rose(rst_n) |-> v == M)
    else $error("enables not set after reset");
  c_write: cover property (wctl);
  c_blocked: cover property (periph_blocked_err);
  c_unmapped: cover property (acc && pslverr);
endmodule
bind pcg_top pcg_properties u_pcg_properties (.*);
`default_nettype wire

/* File: peripheral_clock_gating_test.sv */
// Self-checking bench of the peripheral clock gating block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module peripheral_clock_gating_test;
  import pcg_pkg::*;
  localparam logic [31:0] M = PCG_IMPL_MASK;
  localparam logic [31:0] CT = PCG_POWER_CTRL_ADDR;
  localparam logic [31:0] ST = PCG_STATUS_ADDR;
  localparam logic [31:0] CK = PCG_CLK_STATE_ADDR;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic periph_enable = 0, converter_power_down = 0;
  logic [31:0] paddr = 0, pwdata = 0, periph_sel = 0, prdata, v;
  logic [31:0] periph_sel_gated, clock_enable_vec;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, periph_blocked_ready, periph_blocked_err;
  pcg_enables_t clock_enables;
  logic [32:0] exp_q[$];
  logic [32:0] exp_note;
  int n_mismatch = 0, samples_checked = 0, seed = 79345;
  int bits[11] = '{1, 2, 3, 4, 5, 7, 8, 9, 10, 12, 19};
  always #2.5 clk = ~clk;
  pcg_top u_pcg_top (.*);
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task xfer(input logic w, input logic [31:0] a, d,
            input logic [3:0] s, input logic [32:0] x);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    if (!w) exp_q.push_back(x);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Slave latency is not assumed, only bounded
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin n_mismatch++; tally_and_finish; end
  endtask
  task wr(input logic [31:0] a, d);
    xfer(1'b1, a, d, 4'hF, 33'h0);
  endtask
  task rd(input logic [31:0] a, input logic [32:0] x);
    xfer(1'b0, a, 32'h0, 4'hF, x);
  endtask
  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Read results, oldest note first
  always @(posedge clk) begin
    // One pop per result: the macro reads its expected value twice
    if (psel && penable && !pwrite && pready && exp_q.size() > 0) begin
      exp_note = exp_q.pop_front();
      `CHK("read", exp_note, {pslverr, prdata})
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(CT, {1'b0, M});
    rd(CK, {1'b0, M});
    for (int i = 0; i < 17; i++) begin
      v = (i < 11) ? M & ~(32'h1 << bits[i]) : $random(seed) & M;
      wr(CT, v);
      rd(CT, {1'b0, v});
      rd(CK, {1'b0, v});
    end
    wr(CT, 32'hFFFFFFFF);
    rd(CT, {1'b0, M});
    xfer(1'b1, CT, 32'h0, 4'h2, 33'h0);
    rd(CT, {1'b0, M & ~32'h0000FF00});
    wr(CK, 32'h0);
    rd(CK, {1'b0, M & ~32'h0000FF00});
    rd(32'hE01FC0C8, {1'b1, 32'h0});
    wr(32'hE01FC0C8, 32'h0);
    rd(CT, {1'b0, M & ~32'h0000FF00});
    idle;
    periph_sel <= 32'h1 << PCG_BIT_SYNC0;
    periph_enable <= 1'b1;
    @(posedge clk);
    `CHK("blocked", 1'b1, periph_blocked_err)
    `CHK("gated", 32'h0, periph_sel_gated)
    periph_sel <= 32'h1 << PCG_BIT_SERIAL0;
    @(posedge clk);
    `CHK("open", 1'b0, periph_blocked_ready)
    `CHK("passed", 32'h8, periph_sel_gated)
    periph_enable <= 1'b0;
    periph_sel <= 32'h0;
    @(posedge clk);
    rd(ST, {1'b0, 32'h2});
    wr(ST, 32'h2);
    rd(ST, 33'h0);
    idle;
    converter_power_down <= 1'b1;
    @(posedge clk);
    converter_power_down <= 1'b0;
    rd(ST, {1'b0, 32'h1});
    idle;
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(CT, {1'b0, M});
    idle;
    repeat (2) @(posedge clk);
    `CHK("queue", 0, exp_q.size())
    tally_and_finish;
  end
endmodule
`default_nettype wire
